//--- hw/safety_check_cfg.sv
// safety check control, error monitor bounds and ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "safety_consts.svh"
module safety_check_cfg (
  input  wire logic                  clk,             // 100 mhz clock
  input  wire logic                  reset_n,         // power-on reset, async
  input  wire logic                  dev_reset,       // device reset, sync
  input  wire logic                  hsel,            // ahb select
  input  wire logic [7:0]            haddr,           // ahb address
  input  wire logic [1:0]            htrans,          // ahb transfer type
  input  wire logic                  hwrite,          // ahb write
  input  wire logic [2:0]            hsize,           // ahb size
  input  wire logic [31:0]           hwdata,          // ahb write data
  input  wire logic                  hready,          // ahb ready in
  output logic [31:0]                hrdata,          // ahb read data
  output logic                       hreadyout,       // ahb ready out
  output logic                       hresp,           // ahb response
  input  wire safety_pkg::dev_state_t dev_state,      // device state
  input  wire logic [3:0]            watchdog_failure_count,        // wd fails
  input  wire logic [3:0]            wdog_fail_drive_threshold,     // wd drive th
  input  wire logic [3:0]            wdog_fail_reset_threshold,     // wd reset th
  input  wire logic [3:0]            error_monitor_fail_count,      // esm fails
  input  wire logic [3:0]            error_monitor_drive_threshold, // esm th
  input  wire logic [7:0]            computed_checksum, // live checksum
  input  wire logic [7:0]            expected_config_checksum, // expected
  input  wire logic                  self_test_start, // self test pulse
  input  wire logic                  host_error_input, // host error pin
  output logic                       safety_enable_pin, // enable pin level
  output logic                       crc_check_active,  // checksum running
  output logic                       monitor_active,    // monitor running
  output logic                       monitor_error,     // phase error pulse
  output logic                       diag_to_active,    // leave diag request
  output logic                       irq                // interrupt level
);
  import safety_pkg::*;

  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic [7:0]  hmax_ff, hmin_ff, lmax_ff;
  logic [3:0]  lock_ff, nxt_lock;
  logic [2:0]  stat_ff, nxt_stat, mask_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  waddr_ff;
  logic        wr_ff;
  dev_state_t  prev_state_ff;
  logic        pin_sync1_ff, pin_sync2_ff, pin_prev_ff;
  phase_t      phase_ff, nxt_phase;
  logic [10:0] tick_ff, nxt_tick;
  logic [8:0]  cnt_ff, nxt_cnt;
  logic        err_ff, nxt_err;
  logic        pin_ff, crc_act_ff, mon_act_ff, go_ff, irq_ff;

  // address decode and write qualifiers
  wire        addr_ph   = hsel & htrans[1] & hready;
  wire        wr_ctrl   = wr_ff & (waddr_ff == `OFS_CTRL);
  wire        wr_hmax   = wr_ff & (waddr_ff == `OFS_HMAX);
  wire        wr_hmin   = wr_ff & (waddr_ff == `OFS_HMIN);
  wire        wr_lmax   = wr_ff & (waddr_ff == `OFS_LMAX);
  wire        wr_lock   = wr_ff & (waddr_ff == `OFS_LOCK);
  wire        wr_stat   = wr_ff & (waddr_ff == `OFS_IRQ_STAT);
  wire        wr_mask   = wr_ff & (waddr_ff == `OFS_IRQ_MASK);
  wire        in_diag   = (dev_state == st_diag);
  wire        in_active = (dev_state == st_active);
  wire        ctrl_ok   = ~lock_ff[`LOCK_CTRL];
  wire        cfg_ok    = in_diag & ~lock_ff[`LOCK_CFG];
  wire        wr_bound  = wr_hmax | wr_hmin | wr_lmax;
  wire        refused   = (wr_ctrl & ~ctrl_ok) | (wr_bound & ~cfg_ok);
  wire        enter_safe = (dev_state == st_safe) & (prev_state_ff != st_safe);
  wire        left_diag  = (prev_state_ff == st_diag) & ~in_diag;
  wire        pwm_mode   = lock_ff[`LOCK_MODE];
  wire        esm_on     = ctrl_ff[`CTRL_ESM_EN];
  wire        crc_on     = ctrl_ff[`CTRL_CRC_EN];
  wire        crc_bad    = crc_on & (computed_checksum != expected_config_checksum);
  wire        pin_level  = pin_sync2_ff;
  wire        edge_fall  = pin_prev_ff & ~pin_level;
  wire        edge_rise  = ~pin_prev_ff & pin_level;
  wire [10:0] tick_len   = pwm_mode ? 11'(`TICK_PWM_CYC) : 11'(`TICK_LVL_CYC);
  wire        tick       = (tick_ff == tick_len - 11'h001);
  wire [8:0]  hmax_ticks = {1'b0, hmax_ff} + 9'h001;
  wire [8:0]  hmin_ticks = {1'b0, hmin_ff} + 9'h001;
  wire [8:0]  lmax_ticks = {1'b0, lmax_ff} + 9'h001;
  wire        counts_ok  = (watchdog_failure_count < wdog_fail_drive_threshold)
                         & (watchdog_failure_count < wdog_fail_reset_threshold)
                         & (error_monitor_fail_count < error_monitor_drive_threshold);
  wire        pin_next   = ctrl_ff[`CTRL_PIN_EN] & (in_active | in_diag) & counts_ok;
  wire [2:0]  events     = {refused, crc_bad, err_ff};
  wire [31:0] rd_mux     =
      (haddr == `OFS_CTRL)     ? {24'h000000, ctrl_ff} :
      (haddr == `OFS_HMAX)     ? {24'h000000, hmax_ff} :
      (haddr == `OFS_HMIN)     ? {24'h000000, hmin_ff} :
      (haddr == `OFS_LMAX)     ? {24'h000000, lmax_ff} :
      (haddr == `OFS_LOCK)     ? {28'h0000000, lock_ff} :
      (haddr == `OFS_IRQ_STAT) ? {29'h0, stat_ff} :
      (haddr == `OFS_IRQ_MASK) ? {29'h0, mask_ff} :
      (haddr == `OFS_STATUS)   ? {26'h0, phase_ff, pin_ff, pin_level, dev_state} :
      32'h00000000;

  // control register next value
  always_comb begin
    nxt_ctrl = ctrl_ff;
    // R1: lock gates writes
    if (wr_ctrl & ctrl_ok) begin
      // R19: reserved bits ignored
      nxt_ctrl = (hwdata[7:0] & `CTRL_WMASK) | (ctrl_ff & ~`CTRL_WMASK);
      // R10: leave request only in diagnostic
      if (!in_diag) begin
        nxt_ctrl[`CTRL_LEAVE] = ctrl_ff[`CTRL_LEAVE];
      end
    end
    // R6: safe entry drops pin enable
    if (enter_safe) begin
      nxt_ctrl[`CTRL_PIN_EN] = 1'b0;
    end
    // R11: leaving diagnostic clears request
    if (left_diag | ~in_diag) begin
      nxt_ctrl[`CTRL_LEAVE] = 1'b0;
    end
  end

  always_comb begin
    nxt_lock = lock_ff;
    if (wr_lock) begin
      nxt_lock = hwdata[3:0];
    end
    // R17: self test in diagnostic drops block
    if (self_test_start & in_diag) begin
      nxt_lock[`LOCK_BLOCK] = 1'b0;
    end
  end

  // sticky status, set wins over clear
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = stat_ff & ~hwdata[2:0];
    end
    nxt_stat = nxt_stat | events;
  end

  // R3: control state on both resets
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `RST_CTRL;
    end else if (dev_reset) begin
      ctrl_ff <= `RST_CTRL;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_ff <= `RST_LOCK;
    end else if (dev_reset) begin
      lock_ff <= `RST_LOCK;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  // R3: bounds on power-on only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hmax_ff <= `RST_HMAX;
      hmin_ff <= `RST_HMIN;
      lmax_ff <= `RST_LMAX;
    end else begin
      // R2: bounds need diagnostic and unlocked
      if (wr_hmax & cfg_ok) hmax_ff <= hwdata[7:0];
      if (wr_hmin & cfg_ok) hmin_ff <= hwdata[7:0];
      if (wr_lmax & cfg_ok) lmax_ff <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_ff <= 3'h0;
      mask_ff <= 3'h0;
    end else begin
      stat_ff <= nxt_stat;
      if (wr_mask) mask_ff <= hwdata[2:0];
    end
  end

  // ahb-lite slave, zero wait states
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ff    <= 1'b0;
      waddr_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
    end else begin
      wr_ff    <= addr_ph & hwrite;
      waddr_ff <= haddr;
      // R2: reads always allowed
      if (addr_ph & ~hwrite) rdata_ff <= rd_mux;
    end
  end

  // host error pin synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync1_ff  <= 1'b0;
      pin_sync2_ff  <= 1'b0;
      pin_prev_ff   <= 1'b0;
      prev_state_ff <= st_other;
    end else begin
      pin_sync1_ff  <= host_error_input;
      pin_sync2_ff  <= pin_sync1_ff;
      pin_prev_ff   <= pin_sync2_ff;
      prev_state_ff <= dev_state;
    end
  end

  // phase monitor
  always_comb begin
    nxt_phase = phase_ff;
    nxt_tick  = tick ? 11'h000 : tick_ff + 11'h001;
    nxt_cnt   = (tick && cnt_ff != 9'h1ff) ? cnt_ff + 9'h001 : cnt_ff;
    nxt_err   = 1'b0;
    case (phase_ff)
      ph_idle: begin
        nxt_tick = 11'h000;
        nxt_cnt  = 9'h000;
        nxt_phase = pin_level ? ph_high : ph_low;
      end
      ph_high: begin
        if (edge_fall) begin
          // R14: high phase too short
          nxt_err   = pwm_mode & (cnt_ff < hmin_ticks);
          nxt_phase = ph_low;
          nxt_tick  = 11'h000;
          nxt_cnt   = 9'h000;
        // R13: high phase too long
        end else if (pwm_mode & (cnt_ff == hmax_ticks) & (tick_ff == 11'h000)) begin
          nxt_err = 1'b1;
        end
      end
      ph_low: begin
        if (edge_rise) begin
          nxt_phase = ph_high;
          nxt_tick  = 11'h000;
          nxt_cnt   = 9'h000;
        // R15: low max in pwm mode
        // R16: low max in single-level mode
        end else if ((cnt_ff == lmax_ticks) & (tick_ff == 11'h000)) begin
          nxt_err = 1'b1;
        end
      end
      default: begin
        nxt_phase = ph_idle;
      end
    endcase
  end

  // R9: monitor held idle while disabled
  // R18: ticks and error events
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= ph_idle;
      tick_ff  <= 11'h000;
      cnt_ff   <= 9'h000;
      err_ff   <= 1'b0;
    end else if (!esm_on) begin
      phase_ff <= ph_idle;
      tick_ff  <= 11'h000;
      cnt_ff   <= 9'h000;
      err_ff   <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      tick_ff  <= nxt_tick;
      cnt_ff   <= nxt_cnt;
      err_ff   <= nxt_err;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_ff     <= 1'b0;
      crc_act_ff <= 1'b0;
      mon_act_ff <= 1'b0;
      go_ff      <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      // R7: disabled pin held low
      // R8: pin high needs state and counts
      pin_ff     <= pin_next;
      // R4: checksum check runs while enabled
      crc_act_ff <= crc_on;
      mon_act_ff <= esm_on;
      // R12: leave diagnostic when unblocked
      go_ff      <= ctrl_ff[`CTRL_LEAVE] & ~lock_ff[`LOCK_BLOCK] & in_diag;
      irq_ff     <= |(nxt_stat & mask_ff);
    end
  end

  assign hrdata            = rdata_ff;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign safety_enable_pin = pin_ff;
  assign crc_check_active  = crc_act_ff;
  assign monitor_active    = mon_act_ff;
  assign monitor_error     = err_ff;
  assign diag_to_active    = go_ff;
  assign irq               = irq_ff;

  ctrl_lock_hold_a: assert property ( // R1
    @(posedge clk) disable iff (!reset_n)
    (wr_ctrl & lock_ff[`LOCK_CTRL] & ~dev_reset & ~enter_safe & in_diag & ~left_diag)
      |=> $stable(ctrl_ff[`CTRL_CRC_EN]))
    else $error("locked control write changed crc enable");

  bound_lock_hold_a: assert property ( // R2
    @(posedge clk) disable iff (!reset_n)
    (wr_hmax & ~cfg_ok) |=> $stable(hmax_ff))
    else $error("bound written outside diagnostic or while locked");

  dev_reset_ctrl_a: assert property ( // R3
    @(posedge clk) disable iff (!reset_n)
    (dev_reset & ~wr_lmax) |=> (ctrl_ff == `RST_CTRL) && $stable(lmax_ff))
    else $error("device reset handling wrong");

  crc_follow_a: assert property ( // R4
    @(posedge clk) disable iff (!reset_n)
    crc_check_active == $past(crc_on))
    else $error("checksum activity does not follow enable");

  safe_clear_en_a: assert property ( // R6
    @(posedge clk) disable iff (!reset_n)
    enter_safe |=> ~ctrl_ff[`CTRL_PIN_EN] ##1 ~safety_enable_pin)
    else $error("pin enable not cleared on safe entry");

  pin_low_off_a: assert property ( // R7
    @(posedge clk) disable iff (!reset_n)
    ~ctrl_ff[`CTRL_PIN_EN] |=> ~safety_enable_pin)
    else $error("pin driven while disabled");

  pin_cond_a: assert property ( // R8
    @(posedge clk) disable iff (!reset_n)
    safety_enable_pin |-> $past(counts_ok & (in_active | in_diag)))
    else $error("pin high without conditions");

  monitor_off_a: assert property ( // R9
    @(posedge clk) disable iff (!reset_n)
    ~esm_on |=> (phase_ff == ph_idle) && ~monitor_error)
    else $error("monitor ran while disabled");

  leave_only_diag_a: assert property ( // R10
    @(posedge clk) disable iff (!reset_n)
    ~in_diag |=> ~ctrl_ff[`CTRL_LEAVE])
    else $error("leave request set outside diagnostic");

  leave_go_a: assert property ( // R12
    @(posedge clk) disable iff (!reset_n)
    (ctrl_ff[`CTRL_LEAVE] & ~lock_ff[`LOCK_BLOCK] & in_diag) |=> diag_to_active)
    else $error("leave request not forwarded");

  low_max_err_a: assert property ( // R16
    @(posedge clk) disable iff (!reset_n)
    (esm_on & ~pwm_mode & phase_ff == ph_low & ~edge_rise & tick_ff == 11'h000
      & cnt_ff == lmax_ticks) |=> monitor_error)
    else $error("low phase overrun not flagged");

  self_test_block_a: assert property ( // R17
    @(posedge clk) disable iff (!reset_n)
    (self_test_start & in_diag & ~dev_reset) |=> ~lock_ff[`LOCK_BLOCK])
    else $error("self test did not clear leave block");

  reserved_zero_a: assert property ( // R19
    @(posedge clk) disable iff (!reset_n)
    (ctrl_ff[7:5] == 3'h0) && ~ctrl_ff[1])
    else $error("reserved control bits set");
endmodule

//--- pkg/safety_consts.svh
// offsets, fields, reset values and timing for the safety check block
// Function
// R1: control register writes are taken only while control_write_lock is zero.
// R2: bound writes taken only in diagnostic state with config_write_lock zero; reads always.
// R3: control register resets on power-on and device reset; bounds on power-on only.
// R4: checksum check runs continuously while config_crc_check_enable is set, never otherwise.
// R5: host should update config and expected checksum before enabling the check.
// R6: safety_enable_output_enable clears automatically on entering the safe state.
// R7: with safety_enable_output_enable zero the safety_enable_pin is held low.
// R8: pin high only in active/diagnostic state with all failure counts below thresholds.
// R9: error signal monitor runs only while error_signal_monitor_enable is set.
// R10: diagnostic_leave_request can be set only in the diagnostic state.
// R11: diagnostic_leave_request clears whenever the diagnostic state is left.
// R12: leave request set and leave block clear moves diagnostic to active.
// R13: pwm high-phase maximum is (high max field + 1) times 15 us.
// R14: pwm high-phase minimum is (high min field + 1) times 15 us.
// R15: pwm low-phase maximum is (low max field + 1) times 15 us.
// R16: single-level mode low maximum is (low max field + 1) times 5 us.
// R17: self test started in diagnostic state clears diagnostic_leave_block.
// R18: monitor measures phases in ticks and flags an error on a bound violation.
// R19: reserved control bits 7..5 and 1 read zero and ignore writes.
`ifndef SAFETY_CONSTS_SVH
`define SAFETY_CONSTS_SVH
`define OFS_CTRL       8'h00
`define OFS_HMAX       8'h04
`define OFS_HMIN       8'h08
`define OFS_LMAX       8'h0c
`define OFS_LOCK       8'h10
`define OFS_IRQ_STAT   8'h14
`define OFS_IRQ_MASK   8'h18
`define OFS_STATUS     8'h1c
`define CTRL_CRC_EN    4
`define CTRL_PIN_EN    3
`define CTRL_ESM_EN    2
`define CTRL_LEAVE     0
`define CTRL_WMASK     8'h1d
`define LOCK_CTRL      0
`define LOCK_CFG       1
`define LOCK_BLOCK     2
`define LOCK_MODE      3
`define IRQ_PHASE      0
`define IRQ_CRC        1
`define IRQ_REFUSED    2
`define RST_CTRL       8'h00
`define RST_LOCK       4'h0
`define RST_HMAX       8'ha8
`define RST_HMIN       8'ha7
`define RST_LMAX       8'h3d
`define CLK_MHZ        100
`define TICK_PWM_US    15
`define TICK_LVL_US    5
`define TICK_PWM_CYC   (`TICK_PWM_US * `CLK_MHZ)
`define TICK_LVL_CYC   (`TICK_LVL_US * `CLK_MHZ)
`endif

//--- pkg/safety_pkg.sv
// types shared by the safety check block
package safety_pkg;
  typedef enum logic [1:0] {
    st_diag   = 2'b00,
    st_active = 2'b01,
    st_safe   = 2'b10,
    st_other  = 2'b11
  } dev_state_t;
  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_high = 2'b01,
    ph_low  = 2'b10
  } phase_t;
endpackage

//--- sim/host_err_model.sv
// host-side driver of the error pin: pwm pattern or a held level
`timescale 1ns/1ps
module host_err_model (
  input  wire logic        clk,      // system clock
  input  wire logic        run,      // toggle pattern while set
  input  wire logic        idle_lvl, // level held while not running
  input  wire logic [15:0] high_cyc, // high phase length in cycles
  input  wire logic [15:0] low_cyc,  // low phase length in cycles
  output logic             err_pin   // error pin towards the device
);
  logic [15:0] cnt_ff = 16'h0000;
  initial err_pin = 1'b1;
  // phase lengths chosen by the host
  always @(posedge clk) begin
    if (!run) begin
      cnt_ff <= 16'h0000;
      err_pin <= idle_lvl;
    end else if (cnt_ff + 16'h0001 >= (err_pin ? high_cyc : low_cyc)) begin
      cnt_ff <= 16'h0000;
      err_pin <= ~err_pin;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule

//--- sim/tb.sv
// self-checking bench for the safety check register block
`timescale 1ns/1ps
`include "safety_consts.svh"
module tb;
  import safety_pkg::*;
  logic        clk, hready, hreadyout, hresp, host_error_input;
  logic        reset_n = 1'b0, dev_reset = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  // host loads the expected checksum first
  logic [7:0]  computed_checksum = 8'h5a, expected_config_checksum = 8'h5a;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, hrdata;
  dev_state_t  dev_state = st_diag;
  logic [3:0]  watchdog_failure_count = 4'h0, wdog_fail_drive_threshold = 4'h8;
  logic [3:0]  wdog_fail_reset_threshold = 4'h9, error_monitor_fail_count = 4'h0;
  logic [3:0]  error_monitor_drive_threshold = 4'h8;
  logic        self_test_start = 1'b0, run = 1'b0, idle_lvl = 1'b1;
  logic        safety_enable_pin, crc_check_active, monitor_active, monitor_error, diag_to_active, irq;
  logic [15:0] high_cyc = 16'd3600, low_cyc = 16'd1500;
  int          err_total = 0, total_checks = 0, n;

  assign hready = hreadyout;

  safety_check_cfg dut (
    .clk, .reset_n, .dev_reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .dev_state, .watchdog_failure_count, .wdog_fail_drive_threshold,
    .wdog_fail_reset_threshold, .error_monitor_fail_count, .error_monitor_drive_threshold,
    .computed_checksum, .expected_config_checksum, .self_test_start, .host_error_input,
    .safety_enable_pin, .crc_check_active, .monitor_active, .monitor_error, .diag_to_active, .irq
  );
  host_err_model host (.clk, .run, .idle_lvl, .high_cyc, .low_cyc, .err_pin(host_error_input));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // tests take about 23k cycles
  initial begin
    #500000;
    $display("MISMATCH t=%0t watchdog expired", $time);
    err_total++;
    give_verdict();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr_en;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic pin_case(input logic [3:0] wc, rt, ec, input dev_state_t st, input logic e);
    watchdog_failure_count <= wc;
    wdog_fail_reset_threshold <= rt;
    error_monitor_fail_count <= ec;
    dev_state <= st;
    step(3);
    chk(32'(safety_enable_pin), 32'(e));
  endtask

  // cycles until the next monitor error pulse, lim+1 if none
  task automatic err_win(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (monitor_error !== 1'b1 && n <= lim);
  endtask

  initial begin
    step(12);
    reset_n <= 1'b1;
    step(1);
    rd_chk(`OFS_CTRL, 32'h0000_0000);
    rd_chk(`OFS_HMAX, 32'h0000_00a8);
    rd_chk(`OFS_HMIN, 32'h0000_00a7);
    rd_chk(`OFS_LMAX, 32'h0000_003d);
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(`OFS_STATUS, 32'h0000_0004);
    chk(32'(hresp), 32'h0);
    wr(`OFS_CTRL, 32'hffff_ffff);
    rd_chk(`OFS_CTRL, 32'h0000_001d);
    step(3);
    chk(32'({crc_check_active, monitor_active, diag_to_active, safety_enable_pin}), 32'hf);
    dev_state <= st_active;
    step(3);
    rd_chk(`OFS_CTRL, 32'h0000_001c);
    chk(32'(diag_to_active), 32'h0);
    wr(`OFS_CTRL, 32'h0000_001d);
    rd_chk(`OFS_CTRL, 32'h0000_001c);
    pin_case(4'h7, 4'h9, 4'h7, st_active, 1'b1);
    pin_case(4'h8, 4'h9, 4'h0, st_active, 1'b0);
    pin_case(4'h7, 4'h7, 4'h0, st_active, 1'b0);
    pin_case(4'h0, 4'h9, 4'h8, st_active, 1'b0);
    pin_case(4'h0, 4'h9, 4'h0, st_other, 1'b0);
    pin_case(4'h0, 4'h9, 4'h0, st_diag, 1'b1);
    wr(`OFS_CTRL, 32'h0000_0014);
    pin_case(4'h0, 4'h9, 4'h0, st_active, 1'b0);
    wr(`OFS_CTRL, 32'h0000_0018);
    pin_case(4'h0, 4'h9, 4'h0, st_safe, 1'b0);
    rd_chk(`OFS_CTRL, 32'h0000_0010);
    pin_case(4'h0, 4'h9, 4'h0, st_active, 1'b0);
    wr(`OFS_LOCK, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0004);
    rd_chk(`OFS_CTRL, 32'h0000_0010);
    rd_chk(`OFS_IRQ_STAT, 32'h0000_0004);
    wr(`OFS_IRQ_MASK, 32'h0000_0004);
    step(2);
    chk(32'(irq), 32'h1);
    wr(`OFS_IRQ_STAT, 32'h0000_0004);
    step(2);
    chk(32'(irq), 32'h0);
    wr(`OFS_LOCK, 32'h0000_0000);
    wr(`OFS_HMAX, 32'h0000_0011);
    dev_state <= st_diag;
    wr(`OFS_LOCK, 32'h0000_0002);
    wr(`OFS_HMIN, 32'h0000_0011);
    rd_chk(`OFS_HMAX, 32'h0000_00a8);
    rd_chk(`OFS_HMIN, 32'h0000_00a7);
    wr(`OFS_LOCK, 32'h0000_0000);
    wr(`OFS_HMAX, 32'h0000_0002);
    wr(`OFS_HMIN, 32'h0000_0001);
    wr(`OFS_LMAX, 32'h0000_0001);
    rd_chk(`OFS_LMAX, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0010);
    dev_reset <= 1'b1;
    step(1);
    dev_reset <= 1'b0;
    rd_chk(`OFS_CTRL, 32'h0000_0000);
    rd_chk(`OFS_HMAX, 32'h0000_0002);
    wr(`OFS_IRQ_STAT, 32'h0000_0007);
    computed_checksum <= 8'h5b;
    step(3);
    rd_chk(`OFS_IRQ_STAT, 32'h0000_0000);
    expected_config_checksum <= 8'h5b;
    wr(`OFS_CTRL, 32'h0000_0010);
    step(3);
    rd_chk(`OFS_IRQ_STAT, 32'h0000_0000);
    computed_checksum <= 8'h5c;
    step(3);
    rd_chk(`OFS_IRQ_STAT, 32'h0000_0002);
    wr(`OFS_LOCK, 32'h0000_0004);
    wr(`OFS_CTRL, 32'h0000_0001);
    step(3);
    chk(32'(diag_to_active), 32'h0);
    self_test_start <= 1'b1;
    step(1);
    self_test_start <= 1'b0;
    step(3);
    chk(32'(diag_to_active), 32'h1);
    wr(`OFS_IRQ_STAT, 32'h0000_0007);
    idle_lvl <= 1'b0;
    err_win(1600);
    chk(32'(n > 1600), 32'h1);
    idle_lvl <= 1'b1;
    wr(`OFS_CTRL, 32'h0000_0004);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    step(100);
    chk(32'(monitor_active), 32'h1);
    idle_lvl <= 1'b0;
    err_win(1600);
    chk(32'(n >= 995 && n <= 1030), 32'h1);
    step(2);
    chk(32'(irq), 32'h1);
    wr(`OFS_IRQ_STAT, 32'h0000_0001);
    step(2);
    chk(32'(irq), 32'h0);
    idle_lvl <= 1'b1;
    wr(`OFS_LOCK, 32'h0000_0008);
    run <= 1'b1;
    err_win(12000);
    chk(32'(n > 12000), 32'h1);
    high_cyc <= 16'd1000;
    err_win(6000);
    chk(32'(n <= 6000), 32'h1);
    run <= 1'b0;
    idle_lvl <= 1'b0;
    step(100);
    idle_lvl <= 1'b1;
    err_win(6100);
    chk(32'(n >= 4495 && n <= 4530), 32'h1);
    idle_lvl <= 1'b0;
    err_win(4600);
    chk(32'(n >= 2995 && n <= 3030), 32'h1);
    reset_n <= 1'b0;
    step(2);
    reset_n <= 1'b1;
    step(1);
    rd_chk(`OFS_HMAX, 32'h0000_00a8);
    rd_chk(`OFS_LOCK, 32'h0000_0000);
    give_verdict();
  end
endmodule
